// [hdl/mie_core.sv]
// execute unit for a subset of an 8-bit controller instruction set
// What this block does
// - dest bit 0 to working reg, 1 to file
// - soft_trap pushes PC+1, jumps 001h, three cycles
// - bump_reg increments, sets null flag, one cycle
// - or_reg_wreg ORs file with working, sets flag
// - or_literal ORs immediate into working, sets flag
// - port_cfg_write copies working to port 5/6/7f
// - port_cfg_read copies port 5/6/7f to working
// - far_jump loads 11-bit PC, two cycles
// - far_subcall pushes return, loads PC, two cycles
// - store_wreg copies working into file register
// - load_literal loads immediate, no flags, one cycle
// - copy_reg moves register, sets null flag
// - exit_with_literal loads working and pops PC
// - subroutine_exit pops PC, two cycles
// - exit_and_unmask pops PC, sets interrupt enable
`timescale 1ns/10ps
`default_nettype none

module mie_core
  import mie_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // instruction from fetch
  input  wire mie_insn_t   insn,
  input  wire logic        insn_valid,
  output logic             insn_ready,
  // architectural state
  output mie_arch_t        arch,
  output logic             flush_fetch
);

  typedef struct packed {
    mie_arch_t                 a;
    logic [1:0]                wait_cnt;
    logic [MIE_STACK_AW-1:0]   sp;
    logic                      flush;
  } mie_state_t;

  mie_state_t state;
  mie_state_t next_state;

  // file and stack need many words, kept outside the state struct
  logic [7:0]          file_mem  [MIE_FILE_D];
  logic [10:0]         stack_mem [MIE_STACK_D];
  logic                file_we;
  logic [7:0]          file_wdata;
  logic                push;
  logic [10:0]         push_val;
  logic [7:0]          file_rd;
  logic [10:0]         ret_pc;
  logic [10:0]         pc_inc;
  logic                take;

  function automatic logic is_port_sel(input logic [7:0] sel);
    is_port_sel = (sel == MIE_PORT_A_SEL) || (sel == MIE_PORT_B_SEL) ||
                  (sel == MIE_PORT_C_SEL);
  endfunction

  // zero detect shared by every flag-writing form
  function automatic logic is_nil(input logic [7:0] val);
    is_nil = (val == MIE_ZERO_BYTE);
  endfunction

  // selected control register; an unknown selector leaves the working register as it is
  function automatic logic [7:0] port_read(input mie_arch_t a, input logic [7:0] sel);
    case (sel)
      MIE_PORT_A_SEL: port_read = a.port_cfg_a;
      MIE_PORT_B_SEL: port_read = a.port_cfg_b;
      MIE_PORT_C_SEL: port_read = a.port_cfg_c;
      default:        port_read = a.working_register;
    endcase
  endfunction

  // forms whose result goes through the destination routing
  function automatic logic routes_result(input mie_op_t op);
    case (op)
      MIE_OP_BUMP_REG, MIE_OP_BUMP_SKIP_NIL, MIE_OP_OR_REG_WREG, MIE_OP_COPY_REG,
      MIE_OP_STORE_WREG, MIE_OP_OR_LITERAL, MIE_OP_PORT_CFG_READ,
      MIE_OP_LOAD_LITERAL: routes_result = 1'b1;
      default:             routes_result = 1'b0;
    endcase
  endfunction

  assign file_rd    = file_mem[insn.reg_addr];
  // an empty stack pops a stale entry rather than flagging an error
  assign ret_pc     = stack_mem[state.sp - MIE_SP_STEP];
  assign pc_inc     = state.a.pc + MIE_PC_STEP;
  assign insn_ready = (state.wait_cnt == MIE_WAIT_NONE);
  assign take       = insn_valid && insn_ready;
  assign arch       = state.a;
  assign flush_fetch = state.flush;

  always_comb begin
    logic [7:0] res;
    logic       to_file;
    res        = MIE_ZERO_BYTE;
    to_file    = 1'b0;
    next_state = state;
    file_we    = 1'b0;
    file_wdata = MIE_ZERO_BYTE;
    push       = 1'b0;
    push_val   = pc_inc;
    next_state.flush = 1'b0;
    if (state.wait_cnt != MIE_WAIT_NONE) begin
      next_state.wait_cnt = state.wait_cnt - MIE_WAIT_STEP;
    end else if (take) begin
      next_state.a.pc = pc_inc;
      case (insn.op)
        MIE_OP_SOFT_TRAP: begin
          push                = 1'b1;
          next_state.a.pc     = MIE_TRAP_VECTOR;
          next_state.wait_cnt = MIE_TRAP_WAITS;
          next_state.flush    = 1'b1;
        end
        MIE_OP_BUMP_REG: begin
          res     = file_rd + MIE_ONE_BYTE;
          to_file = insn.dest_file;
          next_state.a.null_result_flag = is_nil(res);
        end
        MIE_OP_BUMP_SKIP_NIL: begin
          res     = file_rd + MIE_ONE_BYTE;
          to_file = insn.dest_file;
          if (is_nil(res)) begin
            // fetched successor is discarded; a dead cycle stands in for it
            next_state.a.pc     = state.a.pc + MIE_SKIP_STEP;
            next_state.wait_cnt = MIE_BRANCH_WAITS;
            next_state.flush    = 1'b1;
          end
        end
        MIE_OP_OR_REG_WREG: begin
          res     = state.a.working_register | file_rd;
          to_file = insn.dest_file;
          next_state.a.null_result_flag = is_nil(res);
        end
        MIE_OP_OR_LITERAL: begin
          res = state.a.working_register | insn.imm[7:0];
          next_state.a.null_result_flag = is_nil(res);
        end
        MIE_OP_PORT_CFG_WRITE: begin
          res = state.a.working_register;
          // unlisted selectors write nothing
          if (is_port_sel(insn.imm[7:0])) begin
            case (insn.imm[7:0])
              MIE_PORT_A_SEL: next_state.a.port_cfg_a = res;
              MIE_PORT_B_SEL: next_state.a.port_cfg_b = res;
              default:        next_state.a.port_cfg_c = res;
            endcase
          end
        end
        MIE_OP_PORT_CFG_READ: begin
          res = port_read(state.a, insn.imm[7:0]);
        end
        MIE_OP_FAR_JUMP: begin
          next_state.a.pc     = insn.imm;
          next_state.wait_cnt = MIE_BRANCH_WAITS;
          next_state.flush    = 1'b1;
        end
        MIE_OP_FAR_SUBCALL: begin
          push                = 1'b1;
          next_state.a.pc     = insn.imm;
          next_state.wait_cnt = MIE_BRANCH_WAITS;
          next_state.flush    = 1'b1;
        end
        MIE_OP_STORE_WREG: begin
          res     = state.a.working_register;
          to_file = 1'b1;
        end
        MIE_OP_LOAD_LITERAL: begin
          res = insn.imm[7:0];
        end
        MIE_OP_COPY_REG: begin
          res     = file_rd;
          to_file = insn.dest_file;
          next_state.a.null_result_flag = is_nil(res);
        end
        MIE_OP_EXIT_WITH_LITERAL, MIE_OP_SUBROUTINE_EXIT, MIE_OP_EXIT_AND_UNMASK: begin
          next_state.a.pc     = ret_pc;
          next_state.sp       = state.sp - MIE_SP_STEP;
          next_state.wait_cnt = MIE_BRANCH_WAITS;
          next_state.flush    = 1'b1;
          if (insn.op == MIE_OP_EXIT_WITH_LITERAL) begin
            next_state.a.working_register = insn.imm[7:0];
          end
          if (insn.op == MIE_OP_EXIT_AND_UNMASK) begin
            next_state.a.int_enable = 1'b1;
          end
        end
        default: begin
        end
      endcase
      // result routing for register and literal forms
      if (routes_result(insn.op)) begin
        if (to_file) begin
          file_we    = 1'b1;
          file_wdata = res;
        end else begin
          next_state.a.working_register = res;
        end
      end
      if (push) begin
        next_state.sp = state.sp + MIE_SP_STEP;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state              <= '0;
      state.a.pc         <= MIE_RESET_PC;
      state.a.port_cfg_a <= MIE_PORT_RESET;
      state.a.port_cfg_b <= MIE_PORT_RESET;
      state.a.port_cfg_c <= MIE_PORT_RESET;
    end else begin
      state <= next_state;
    end
  end

  // memories carry no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (file_we) begin
      file_mem[insn.reg_addr] <= file_wdata;
    end
    if (push) begin
      // oldest entry is overwritten silently when full
      stack_mem[state.sp] <= push_val;
    end
  end

endmodule // mie_core

`default_nettype wire

// [common/mie_pkg.sv]
// package: opcode set, field layout and constants of the partial execute unit
package mie_pkg;

  localparam int MIE_PC_W       = 11;
  localparam int MIE_STACK_D    = 8;
  localparam int MIE_STACK_AW   = 3;
  localparam int MIE_FILE_D     = 128;
  localparam logic [10:0] MIE_TRAP_VECTOR = 11'h001;
  localparam logic [10:0] MIE_RESET_PC    = 11'h000;
  localparam logic [7:0]  MIE_PORT_A_SEL  = 8'h05;
  localparam logic [7:0]  MIE_PORT_B_SEL  = 8'h06;
  localparam logic [7:0]  MIE_PORT_C_SEL  = 8'h7f;
  localparam logic [7:0]  MIE_PORT_RESET  = 8'hff;
  localparam logic [7:0]  MIE_ZERO_BYTE   = 8'h00;
  localparam logic [7:0]  MIE_ONE_BYTE    = 8'h01;
  localparam logic [1:0]  MIE_TRAP_WAITS  = 2'h2;
  localparam logic [1:0]  MIE_BRANCH_WAITS = 2'h1;
  localparam logic [1:0]  MIE_WAIT_NONE   = 2'h0;
  localparam logic [1:0]  MIE_WAIT_STEP   = 2'h1;
  localparam logic [10:0] MIE_PC_STEP     = 11'h001;
  localparam logic [10:0] MIE_SKIP_STEP   = 11'h002;
  localparam logic [2:0]  MIE_SP_STEP     = 3'h1;

  typedef enum logic [3:0] {
    MIE_OP_NOP,
    MIE_OP_SOFT_TRAP,
    MIE_OP_BUMP_REG,
    MIE_OP_BUMP_SKIP_NIL,
    MIE_OP_OR_REG_WREG,
    MIE_OP_OR_LITERAL,
    MIE_OP_PORT_CFG_WRITE,
    MIE_OP_PORT_CFG_READ,
    MIE_OP_FAR_JUMP,
    MIE_OP_FAR_SUBCALL,
    MIE_OP_STORE_WREG,
    MIE_OP_LOAD_LITERAL,
    MIE_OP_COPY_REG,
    MIE_OP_EXIT_WITH_LITERAL,
    MIE_OP_SUBROUTINE_EXIT,
    MIE_OP_EXIT_AND_UNMASK
  } mie_op_t;

  // one decoded instruction as presented by the fetch stage
  typedef struct packed {
    mie_op_t     op;
    logic        dest_file;
    logic [6:0]  reg_addr;
    logic [10:0] imm;
  } mie_insn_t;

  // architectural view exported to the rest of the core
  typedef struct packed {
    logic [10:0] pc;
    logic [7:0]  working_register;
    logic        null_result_flag;
    logic        int_enable;
    logic [7:0]  port_cfg_a;
    logic [7:0]  port_cfg_b;
    logic [7:0]  port_cfg_c;
  } mie_arch_t;

endpackage : mie_pkg

// [testbench/mie_monitor.sv]
// port checker of the partial execute unit
`timescale 1ns/10ps
`default_nettype none
module mie_monitor
  import mie_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst_b,
  input wire mie_insn_t insn,
  input wire logic      insn_valid,
  input wire logic      insn_ready,
  input wire mie_arch_t arch,
  input wire logic      flush_fetch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic    tk;
  mie_op_t op;
  assign tk = insn_valid && insn_ready;
  assign op = insn.op;
  a_trap_vector: assert property (tk && op == MIE_OP_SOFT_TRAP |=>
    arch.pc == 11'h001 && !insn_ready ##1 !insn_ready ##1 insn_ready) else $error("trap");
  a_jump_load: assert property (tk && op == MIE_OP_FAR_JUMP |=>
    arch.pc == $past(insn.imm) && !insn_ready ##1 insn_ready) else $error("jump");
  a_call_load: assert property (tk && op == MIE_OP_FAR_SUBCALL |=>
    arch.pc == $past(insn.imm) && flush_fetch ##1 insn_ready) else $error("call");
  a_lit_load: assert property (tk && op == MIE_OP_LOAD_LITERAL |=>
    arch.working_register == $past(insn.imm[7:0]) && $stable(arch.null_result_flag)
    && insn_ready) else $error("literal");
  a_or_lit: assert property (tk && op == MIE_OP_OR_LITERAL |=>
    arch.working_register == ($past(arch.working_register) | $past(insn.imm[7:0]))
    && arch.null_result_flag == (arch.working_register == 8'h00)) else $error("or");
  a_port_write: assert property (tk && op == MIE_OP_PORT_CFG_WRITE && insn.imm[7:0] == 8'h05
    |=> arch.port_cfg_a == $past(arch.working_register)) else $error("port");
  a_exit_lit: assert property (tk && op == MIE_OP_EXIT_WITH_LITERAL |=>
    arch.working_register == $past(insn.imm[7:0]) && !insn_ready ##1 insn_ready) else $error("retlit");
  a_unmask_exit: assert property (tk && op == MIE_OP_EXIT_AND_UNMASK |=>
    arch.int_enable && flush_fetch ##1 insn_ready) else $error("unmask");
  c_trap: cover property (tk && op == MIE_OP_SOFT_TRAP);
  c_skip: cover property (tk && op == MIE_OP_BUMP_SKIP_NIL ##1 flush_fetch);
  c_unmask: cover property (arch.int_enable);
endmodule // mie_monitor
bind mie_core mie_monitor i_mon (.clk(clk), .rst_b(rst_b), .insn(insn), .insn_valid(insn_valid),
  .insn_ready(insn_ready), .arch(arch), .flush_fetch(flush_fetch));
`default_nettype wire

// [testbench/mie_core_bench.sv]
// self-checking bench of the partial execute unit
`timescale 1ns/10ps
`default_nettype none
module mie_core_bench
  import mie_pkg::*;
;
  typedef struct packed {
    mie_op_t    op;
    logic       d;
    logic [6:0] a;
    logic [7:0] im;
    logic [7:0] wr;
    logic       z;
  } mie_row_t;
  logic      clk = 1'b0;
  logic      rst_b = 1'b1;
  mie_insn_t insn = '0;
  logic      insn_valid = 1'b0;
  logic      insn_ready;
  mie_arch_t arch;
  logic      flush_fetch;
  int        n_fail = 0;
  int        n_compared = 0;
  // rows chain: each expects the state left by the ones before
  mie_row_t  rows [14] = '{
    '{MIE_OP_OR_LITERAL, 0, 7'h00, 8'h00, 8'h00, 1}, '{MIE_OP_LOAD_LITERAL, 0, 7'h00, 8'h5a, 8'h5a, 1},
    '{MIE_OP_STORE_WREG, 0, 7'h10, 8'h00, 8'h5a, 1}, '{MIE_OP_BUMP_REG, 1, 7'h10, 8'h00, 8'h5a, 0},
    '{MIE_OP_OR_REG_WREG, 0, 7'h10, 8'h00, 8'h5b, 0}, '{MIE_OP_PORT_CFG_WRITE, 0, 7'h00, 8'h06, 8'h5b, 0},
    '{MIE_OP_LOAD_LITERAL, 0, 7'h00, 8'hff, 8'hff, 0}, '{MIE_OP_STORE_WREG, 0, 7'h11, 8'h00, 8'hff, 0},
    '{MIE_OP_BUMP_REG, 0, 7'h11, 8'h00, 8'h00, 1}, '{MIE_OP_PORT_CFG_READ, 0, 7'h00, 8'h06, 8'h5b, 1},
    '{MIE_OP_COPY_REG, 1, 7'h11, 8'h00, 8'h5b, 0}, '{MIE_OP_PORT_CFG_READ, 0, 7'h00, 8'h07, 8'h5b, 0},
    '{MIE_OP_PORT_CFG_WRITE, 0, 7'h00, 8'h05, 8'h5b, 0}, '{MIE_OP_PORT_CFG_WRITE, 0, 7'h00, 8'h7f, 8'h5b, 0}};

  mie_core i_dut (.clk(clk), .rst_b(rst_b), .insn(insn), .insn_valid(insn_valid),
    .insn_ready(insn_ready), .arch(arch), .flush_fetch(flush_fetch));

  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [46:0] exp, input logic [46:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hold the offer until the edge that finds ready high, then drop it
  task automatic issue(input mie_op_t op, input logic d, input logic [6:0] a, input logic [10:0] im);
    int k;
    k = 0;
    @(posedge clk);
    insn <= '{op, d, a, im};
    insn_valid <= 1'b1;
    @(negedge clk);
    while (insn_ready !== 1'b1 && k < 9) begin
      k++;
      @(negedge clk);
    end
    if (k == 9) n_fail++;
    @(posedge clk);
    insn_valid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic br(input mie_op_t op, input logic [10:0] im, input logic [10:0] pc);
    issue(op, 1'b0, 7'h00, im);
    chk("branch", {pc, 2'h1}, {arch.pc, insn_ready, flush_fetch});
  endtask

  task automatic rst_chk();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("reset", {11'h000, 8'h00, 2'h0, 24'hffffff, 2'h2}, {arch, insn_ready, flush_fetch});
  endtask

  initial begin
    rst_chk();
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].d, rows[i].a, {3'h0, rows[i].im});
      chk("wreg_flag", {rows[i].wr, rows[i].z}, {arch.working_register, arch.null_result_flag});
    end
    chk("ports", 24'h5b5b5b, {arch.port_cfg_a, arch.port_cfg_b, arch.port_cfg_c});
    br(MIE_OP_FAR_JUMP, 11'h7f0, 11'h7f0);
    br(MIE_OP_FAR_SUBCALL, 11'h123, 11'h123);
    br(MIE_OP_SOFT_TRAP, 11'h000, 11'h001);
    br(MIE_OP_SUBROUTINE_EXIT, 11'h000, 11'h124);
    br(MIE_OP_EXIT_WITH_LITERAL, 11'h03c, 11'h7f1);
    chk("wreg", 8'h3c, arch.working_register);
    br(MIE_OP_FAR_SUBCALL, 11'h200, 11'h200);
    br(MIE_OP_EXIT_AND_UNMASK, 11'h000, 11'h7f2);
    chk("int_enable", 1'b1, arch.int_enable);
    issue(MIE_OP_LOAD_LITERAL, 1'b0, 7'h00, 11'h0ff);
    issue(MIE_OP_STORE_WREG, 1'b0, 7'h12, 11'h000);
    issue(MIE_OP_BUMP_SKIP_NIL, 1'b1, 7'h12, 11'h000);
    chk("skip", 11'h7f9, {arch.working_register, arch.null_result_flag, insn_ready, flush_fetch});
    issue(MIE_OP_BUMP_SKIP_NIL, 1'b0, 7'h12, 11'h000);
    chk("noskip", 11'h00a, {arch.working_register, arch.null_result_flag, insn_ready, flush_fetch});
    for (int j = 0; j < 9; j++) br(MIE_OP_FAR_SUBCALL, 11'(j * 16), 11'(j * 16));
    for (int j = 7; j >= 0; j--) br(MIE_OP_SUBROUTINE_EXIT, 11'h000, 11'(j * 16 + 1));
    br(MIE_OP_SUBROUTINE_EXIT, 11'h000, 11'h071);
    rst_chk();
    complete_run();
  end

  initial begin
    #100us;
    n_fail++;
    complete_run();
  end
endmodule // mie_core_bench
`default_nettype wire
